/* rtl/srm_core.sv */
`timescale 1ns/1ns
// How it works
// RQ1: Low wake op copies flags 0-3.
// RQ2: High wake op copies flags 4-7.
// RQ3: Low bit 0 marks divider 0 wake.
// RQ4: Low bit 1 marks timer 0 wake.
// RQ5: Low bit 2 marks port wake.
// RQ6: High bit 0 marks divider 1 wake.
// RQ7: High bit 1 marks timer 1 wake.
// RQ8: Read page op copies page register.
// RQ9: Port change op copies change flags.
// RQ10: Change flag set when its pin changed.
// RQ11: Working move copies selected working register.
// RQ12: Every move updates the zero flag.
// RQ13: Page register loaded by write-page op.
// RQ14: Reserved wake bits read as zero.
module srm_core import srm_pkg::*; (
    input wire logic mclk, // Core clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic instr_valid, // One machine cycle of instruction issue.
    input wire logic [15:0] instr, // Instruction word.
    input wire srm_wake_t wake_evt, // Wake-cause event pulses, same clock.
    input wire logic wake_clr, // Clears wake-cause flags on halt entry.
    input wire logic [3:0] port_pins, // Wake input port pins, asynchronous.
    input wire logic port_chg_clr, // Clears the port change flags.
    input wire logic [3:0] mem_rdata, // Data memory nibble at the address field.
    output logic [3:0] acc, // Accumulator.
    output logic zero_flag, // Zero flag.
    output srm_memwr_t mem_wr, // Data memory write request.
    output logic [3:0] page_out // Page register value.
);

    // ****************************************************************
    // Decode
    // ****************************************************************

    srm_src_t src;
    logic [6:0] addr;
    logic [3:0] wsel;

    srm_decode srm_decode_inst (
        .instr(instr),
        .src(src),
        .addr(addr),
        .wsel(wsel)
    );

    // ****************************************************************
    // State
    // ****************************************************************

    logic [2:0] wake_low_reg;
    logic [1:0] wake_high_reg;
    logic [3:0] pin_s1_reg, pin_s2_reg, pin_last_reg;
    logic [3:0] port_chg_reg;
    logic [3:0] page_reg;
    logic [3:0] work_reg [2**NIB_W];
    logic [3:0] acc_reg;
    logic zero_flag_reg;
    srm_memwr_t memwr_reg;

    wire issue = instr_valid && src != SRC_NONE;

    // Wake-cause nibbles; reserved positions are forced to zero.
    wire [3:0] wake_low_nib = {1'b0, wake_low_reg}; // RQ14
    wire [3:0] wake_high_nib = {2'b00, wake_high_reg}; // RQ14

    // Working registers are the first sixteen data memory nibbles, so a mirror is kept here.
    wire work_hit = addr[6:4] == FLAG_ZERO;

    // ****************************************************************
    // Source select
    // ****************************************************************

    logic [3:0] move_data;
    always_comb begin
        case (src)
            SRC_WAKE_LOW: move_data = wake_low_nib; // RQ1
            SRC_WAKE_HIGH: move_data = wake_high_nib; // RQ2
            SRC_PAGE: move_data = page_reg; // RQ8
            SRC_PORT: move_data = port_chg_reg; // RQ9
            SRC_WORK: move_data = work_reg[wsel]; // RQ11
            default: move_data = NIB_ZERO;
        endcase
    end

    wire moves_acc = issue && src != SRC_PAGE_WR;

    // ****************************************************************
    // Wake-cause flags
    // ****************************************************************

    // Sticky until the halt logic clears them; a new event in the clear cycle still sets.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_low_reg <= FLAG_ZERO;
            wake_high_reg <= 2'b00;
        end else begin
            wake_low_reg[WL_DIV0_BIT] <= wake_evt.div0_ovf | (wake_low_reg[WL_DIV0_BIT] & ~wake_clr); // RQ3
            wake_low_reg[WL_TMR0_BIT] <= wake_evt.tmr0_udf | (wake_low_reg[WL_TMR0_BIT] & ~wake_clr); // RQ4
            wake_low_reg[WL_PORT_BIT] <= wake_evt.port_chg | (wake_low_reg[WL_PORT_BIT] & ~wake_clr); // RQ5
            wake_high_reg[WH_DIV1_BIT] <= wake_evt.div1_ovf | (wake_high_reg[WH_DIV1_BIT] & ~wake_clr); // RQ6
            wake_high_reg[WH_TMR1_BIT] <= wake_evt.tmr1_udf | (wake_high_reg[WH_TMR1_BIT] & ~wake_clr); // RQ7
        end
    end

    // ****************************************************************
    // Port change detection
    // ****************************************************************

    // Pins are synchronised first; the edge compare uses the second stage and its one-cycle delayed copy.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_s1_reg <= NIB_ZERO;
            pin_s2_reg <= NIB_ZERO;
            pin_last_reg <= NIB_ZERO;
        end else begin
            pin_s1_reg <= port_pins;
            pin_s2_reg <= pin_s1_reg;
            pin_last_reg <= pin_s2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NIB_W; gi++) begin : g_chg
            // A change seen in the clear cycle wins over the clear.
            always_ff @(posedge mclk) begin
                if (rst) begin
                    port_chg_reg[gi] <= 1'b0;
                end else begin
                    port_chg_reg[gi] <= (pin_s2_reg[gi] ^ pin_last_reg[gi]) | (port_chg_reg[gi] & ~port_chg_clr); // RQ10
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Page and working registers
    // ****************************************************************

    always_ff @(posedge mclk) begin
        if (rst) begin
            page_reg <= NIB_ZERO;
        end else if (issue && src == SRC_PAGE_WR) begin
            page_reg <= mem_rdata; // RQ13
        end
    end

    // The mirror follows every move into the working register area.
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 2**NIB_W; i++) begin
                work_reg[i] <= NIB_ZERO;
            end
        end else if (moves_acc && work_hit) begin
            work_reg[addr[3:0]] <= move_data; // RQ11
        end
    end

    // ****************************************************************
    // Accumulator, zero flag and memory write
    // ****************************************************************

    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_reg <= NIB_ZERO;
            zero_flag_reg <= 1'b0;
            memwr_reg <= '0;
        end else begin
            memwr_reg.wr_en <= moves_acc; // RQ1
            memwr_reg.wr_addr <= addr;
            memwr_reg.wr_data <= move_data;
            if (moves_acc) begin
                acc_reg <= move_data;
                zero_flag_reg <= move_data == NIB_ZERO; // RQ12
            end
        end
    end

    assign acc = acc_reg;
    assign zero_flag = zero_flag_reg;
    assign mem_wr = memwr_reg;
    assign page_out = page_reg;

endmodule

/* rtl/srm_pkg.sv */
package srm_pkg;

    // ****************************************************************
    // Instruction word layout
    // ****************************************************************

    localparam int INSTR_W = 16;
    localparam int ADDR_W = 7;
    localparam int NIB_W = 4;
    localparam int MEM_DEPTH = 128;

    // Opcode patterns, left aligned in the 16-bit word.
    localparam logic [8:0] OPC_WAKE_LOW = 9'h092;
    localparam logic [8:0] OPC_PORT_CHG = 9'h09e;
    localparam logic [9:0] OPC_READ_PAGE = 10'h17f;
    localparam logic [7:0] OPC_WRITE_PAGE = 8'h5d;
    localparam logic [3:0] OPC_MOVE_WORK = 4'h7;

    // The high-nibble opcode is not fixed by the table; it is a free parameter.
    localparam logic [8:0] OPC_WAKE_HIGH = 9'h093;

    // Bit positions inside the wake-cause result nibbles.
    localparam int WL_DIV0_BIT = 0;
    localparam int WL_TMR0_BIT = 1;
    localparam int WL_PORT_BIT = 2;
    localparam int WH_DIV1_BIT = 0;
    localparam int WH_TMR1_BIT = 1;

    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [2:0] FLAG_ZERO = 3'h0;

    // Source selection for the moved nibble.
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_WAKE_LOW = 3'b001,
        SRC_WAKE_HIGH = 3'b010,
        SRC_PAGE = 3'b011,
        SRC_PORT = 3'b100,
        SRC_WORK = 3'b101,
        SRC_PAGE_WR = 3'b110
    } srm_src_t;

    // Wake-cause event pulses from the divider, timer and port logic.
    typedef struct packed {
        logic div0_ovf;
        logic tmr0_udf;
        logic port_chg;
        logic div1_ovf;
        logic tmr1_udf;
    } srm_wake_t;

    // Result of one move: data memory write enable, address and data.
    typedef struct packed {
        logic wr_en;
        logic [6:0] wr_addr;
        logic [3:0] wr_data;
    } srm_memwr_t;

endpackage

/* rtl/srm_decode.sv */
`timescale 1ns/1ns
module srm_decode import srm_pkg::*; (
    input wire logic [15:0] instr, // Instruction word.
    output srm_src_t src, // Selected source.
    output logic [6:0] addr, // Data memory address field.
    output logic [3:0] wsel // Working register field.
);

    // ****************************************************************
    // Opcode match
    // ****************************************************************

    // Read-page, the longest pattern, is tested first, so read-page is never mistaken for write-page.
    wire is_page = instr[15:6] == OPC_READ_PAGE; // RQ8
    wire is_page_wr = instr[15:8] == OPC_WRITE_PAGE && !is_page; // RQ13
    wire is_low = instr[15:7] == OPC_WAKE_LOW; // RQ1
    wire is_high = instr[15:7] == OPC_WAKE_HIGH; // RQ2
    wire is_port = instr[15:7] == OPC_PORT_CHG; // RQ9
    wire is_work = instr[15:12] == OPC_MOVE_WORK; // RQ11

    assign src = is_page ? SRC_PAGE : is_page_wr ? SRC_PAGE_WR : is_low ? SRC_WAKE_LOW :
        is_high ? SRC_WAKE_HIGH : is_port ? SRC_PORT : is_work ? SRC_WORK : SRC_NONE;
    assign addr = instr[6:0];
    assign wsel = instr[10:7];

endmodule

/* dv/srm_core_properties.sv */
`timescale 1ns/1ns
// ****************************************************************
// Port checker for the special register moves
// ****************************************************************
module srm_props import srm_pkg::*; (
    input wire logic mclk, // Clock.
    input wire logic rst, // Reset.
    input wire logic instr_valid, // Issue.
    input wire logic [15:0] instr, // Word.
    input wire srm_wake_t wake_evt, // Events.
    input wire logic wake_clr, // Clear.
    input wire logic [3:0] port_pins, // Pins.
    input wire logic port_chg_clr, // Clear.
    input wire logic [3:0] mem_rdata, // Nibble.
    input wire logic [3:0] acc, // Acc.
    input wire logic zero_flag, // Zero.
    input wire srm_memwr_t mem_wr, // Write.
    input wire logic [3:0] page_out // Page.
);
    // Issue strobes per operation; every op but write-page is a move.
    wire lo = instr_valid && instr[15:7] == OPC_WAKE_LOW;
    wire hi = instr_valid && instr[15:7] == OPC_WAKE_HIGH;
    wire pc = instr_valid && instr[15:7] == OPC_PORT_CHG;
    wire rp = instr_valid && instr[15:6] == OPC_READ_PAGE;
    wire wp = instr_valid && instr[15:8] == OPC_WRITE_PAGE;
    wire mv = lo || hi || pc || rp || (instr_valid && instr[15:12] == OPC_MOVE_WORK);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_move_writes: assert property (mv |=> mem_wr.wr_en && mem_wr.wr_addr == $past(instr[6:0]))
        else $error("move write missing");
    a_acc_mem_zero: assert property (mem_wr.wr_en |-> mem_wr.wr_data == acc && zero_flag == (acc == 4'h0))
        else $error("acc or zero flag mismatch");
    a_acc_hold: assert property (!mv |=> $stable(acc) && $stable(zero_flag))
        else $error("acc changed without move");
    a_page_read: assert property (rp |=> acc == $past(page_out))
        else $error("page read wrong");
    a_page_load: assert property (wp |=> page_out == $past(mem_rdata))
        else $error("page load wrong");
    a_low_resv: assert property (lo |=> !acc[3])
        else $error("low reserved bit set");
    a_high_resv: assert property (hi |=> acc[3:2] == 2'b00)
        else $error("high reserved bits set");
    a_low_divider: assert property (lo && $past(wake_evt.div0_ovf) |=> acc[0])
        else $error("divider wake lost");
    a_high_timer: assert property (wake_evt.tmr1_udf ##1 !wake_clr ##1 hi |=> acc[1])
        else $error("timer wake lost");
endmodule

bind srm_core srm_props srm_props_inst (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .wake_evt(wake_evt), .wake_clr(wake_clr), .port_pins(port_pins), .port_chg_clr(port_chg_clr),
    .mem_rdata(mem_rdata), .acc(acc), .zero_flag(zero_flag), .mem_wr(mem_wr), .page_out(page_out));

/* dv/srm_core_test.sv */
`timescale 1ns/1ns
module srm_core_test import srm_pkg::*;;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic wake_clr = 1'b0;
    logic port_chg_clr = 1'b0;
    logic [15:0] instr = 16'h0000;
    srm_wake_t wake_evt = '0;
    srm_wake_t w;
    logic [3:0] port_pins = 4'h0;
    logic [3:0] mem_rdata = 4'h0;
    logic [3:0] acc, page_out, m, last;
    logic [3:0] wreg [16];
    logic [6:0] a;
    logic zero_flag;
    srm_memwr_t mem_wr;
    int miscompares = 0;
    int tests_run = 0;
    always #2 mclk = ~mclk;
    srm_core srm_core_inst (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .wake_evt(wake_evt), .wake_clr(wake_clr), .port_pins(port_pins), .port_chg_clr(port_chg_clr),
        .mem_rdata(mem_rdata), .acc(acc), .zero_flag(zero_flag), .mem_wr(mem_wr), .page_out(page_out));
    // Reserved positions are forced to zero in the expected nibbles.
    function automatic logic [3:0] exp_low(srm_wake_t v);
        return {1'b0, v.port_chg, v.tmr0_udf, v.div0_ovf};
    endfunction
    function automatic logic [3:0] exp_high(srm_wake_t v);
        return {2'b00, v.tmr1_udf, v.div1_ovf};
    endfunction
    task automatic test_done();
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_nib(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_wr(input srm_memwr_t got, input srm_memwr_t exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // All drives land 1 ns after the edge, so nothing races the sampling edge.
    task automatic idle(input int n);
        instr_valid = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic issue(input logic [15:0] op);
        instr = op;
        instr_valid = 1'b1;
        @(posedge mclk);
        #1;
    endtask
    // A move also refreshes the working register mirror when it lands low.
    task automatic move(input logic [15:0] op, input logic [3:0] exp);
        issue(op);
        cmp_nib(acc, exp);
        cmp_nib({3'h0, zero_flag}, {3'h0, exp == 4'h0});
        cmp_wr(mem_wr, {1'b1, op[6:0], exp});
        if (op[6:4] == 3'h0) begin
            wreg[op[3:0]] = exp;
        end
        last = exp;
    endtask
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
    initial begin
        for (int i = 0; i < 16; i++) begin
            wreg[i] = 4'h0;
        end
        void'($urandom(32'hf3f5));
        repeat (8) @(posedge mclk);
        #1;
        rst = 1'b0;
        cmp_nib(page_out, 4'h0);
        for (int i = 0; i < 40; i++) begin
            w = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : 5'($urandom);
            wake_clr = 1'b1;
            idle(1);
            wake_clr = 1'b0;
            wake_evt = w;
            idle(1);
            wake_evt = '0;
            a = 7'($urandom_range(31));
            move({OPC_WAKE_LOW, a}, exp_low(w));
            move({OPC_WAKE_HIGH, a ^ 7'h01}, exp_high(w));
            port_chg_clr = 1'b1;
            idle(1);
            port_chg_clr = 1'b0;
            m = 4'($urandom);
            port_pins = port_pins ^ m;
            idle(4);
            move({OPC_PORT_CHG, a}, m);
            m = 4'($urandom);
            mem_rdata = m;
            issue({OPC_WRITE_PAGE, 1'b0, a});
            cmp_nib(page_out, m);
            cmp_nib(acc, last);
            move({OPC_READ_PAGE, a[5:0]}, m);
            m = 4'($urandom_range(15));
            move({OPC_MOVE_WORK, 1'b0, m, a}, wreg[m]);
            issue(16'h0000);
            cmp_nib({3'h0, mem_wr.wr_en}, 4'h0);
            cmp_nib(acc, last);
            idle(1);
        end
        // A reset in mid-run drops every output and the sticky flags; events under reset are ignored.
        rst = 1'b1;
        wake_evt = 5'h1f;
        idle(1);
        wake_evt = '0;
        idle(1);
        rst = 1'b0;
        cmp_nib(acc, 4'h0);
        cmp_nib({3'h0, zero_flag}, 4'h0);
        cmp_nib(page_out, 4'h0);
        cmp_wr(mem_wr, '0);
        move({OPC_WAKE_LOW, 7'h20}, 4'h0);
        move({OPC_WAKE_HIGH, 7'h21}, 4'h0);
        test_done();
    end
endmodule
